// file: rtl/bmc_device.sv
// monitor device end of the serial command port
// Behaviour
// RULE_01: idle-low clock, sample falling, launch rising
// RULE_02: accept 32 or 16-bit bursts, reassemble word
// RULE_03: registers 32-bit words, conversions 64-bit words
// RULE_04: start 32-bit, conversions go 64, 0x04 returns
// RULE_05: conversion read once, reread zero, life kept
// RULE_06: bits 25..20 are register address
// RULE_07: bits 19..12 are 8-bit write data
// RULE_08: bit 26 high: unidirectional, 725 kHz max
// RULE_09: bit 26 low: bidirectional, 500 kHz max
// RULE_10: host waits 50 us before going unidirectional
// RULE_11: bad 12-bit check code blocks the write
// RULE_12: check code polynomial 0xB41 Koopman
// RULE_13: read via select 0x3F then null frames
// RULE_14: 5-bit address, reset 0x00, 0x1F broadcast
// RULE_15: watchdog 8.192 ms steps, write restarts
// RULE_16: watchdog enabled at reset, code 0x0C
// RULE_17: disable by 0x00, key 0x5A, 0x00
// RULE_18: any other command aborts disable sequence
// RULE_19: partial power-down still expires into full
// RULE_20: expiry gives full power-down until wake toggles
// RULE_21: host sets timer, hw_powerdown_select, then drops wake
// RULE_22: wake high at timer expiry keeps master up
// RULE_23: zero timer: immediate power-down on wake low
// RULE_24: short or long burst discards the frame
`timescale 1ns/1ns
module bmc_device import bmc_pkg::*; #(
  parameter logic [31:0] WDOG_STEP_CYC = WDOG_STEP_CYC_DEF,
  parameter logic [31:0] PDT_STEP_CYC  = PDT_STEP_CYC_DEF
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  bmc_spi_if.dev           spi,
  input  wire logic        convValid,
  input  wire logic [63:0] convWord,
  output logic             linkUnidir,
  output logic             wideMode,
  output logic             partialPd,
  output logic             fullPd,
  output logic             crcFault
);
  typedef enum logic [1:0] {
    WS_IDLE  = 2'b00,
    WS_ZERO  = 2'b01,
    WS_KEYED = 2'b10
  } bmc_wdseq_t;

  logic [3:0]  pinMeta_ff, pinSync_ff, pinLast_ff;
  logic        sclkRise, sclkFall, csLow, csRise, wakeEdge;
  logic [5:0]  burstCnt_ff;
  logic [4:0]  inCnt_ff;
  logic [31:0] inShift_ff;
  logic        burstOk, frameDone, isNull, crcOk, addrHit, exec;
  logic [5:0]  wrAddr;
  logic [7:0]  wrData;
  logic [11:0] inCrc, rdCrc;
  logic [5:0]  outCnt_ff;
  logic [63:0] outShift_ff, loadWord;
  logic        miso_ff;
  logic [63:0] convBuf_ff;
  logic        convFresh_ff, wide_ff, linkUni_ff, fullPd_ff, crcFault_ff;
  logic [7:0]  ctrl1_ff, adcCtl_ff, pdtReg_ff, wdtReg_ff, wdtKey_ff, rdSel_ff, rdVal;
  logic [4:0]  devAddr_ff;
  logic [19:0] rdHead;
  bmc_wdseq_t  wdSeq_ff, nxt_wdSeq;
  logic [31:0] wdStep_ff, pdStep_ff;
  logic [7:0]  wdNum_ff, pdNum_ff;
  logic        wdEn_ff, wdExpire, pdDone, hw_powerdown_select;

  // pins come from the host domain: two stages before any use
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinMeta_ff <= PIN_IDLE;
      pinSync_ff <= PIN_IDLE;
      pinLast_ff <= PIN_IDLE;
    end else begin
      pinMeta_ff <= {spi.ioSupplyWake, spi.mosi, spi.csN, spi.sclk};
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end

  // RULE_01: edge detect on idle-low clock
  assign sclkRise = pinSync_ff[0] & ~pinLast_ff[0];
  assign sclkFall = ~pinSync_ff[0] & pinLast_ff[0];
  assign csLow    = ~pinSync_ff[1];
  assign csRise   = pinSync_ff[1] & ~pinLast_ff[1];
  assign wakeEdge = pinSync_ff[3] ^ pinLast_ff[3];

  // RULE_24: only whole 16 or 32 clock bursts count
  assign burstOk = (burstCnt_ff == BURST_SHORT) || (burstCnt_ff == BURST_LONG);

  // RULE_02: inbound bits gather into one word across bursts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      burstCnt_ff <= 6'h00;
      inCnt_ff    <= 5'h00;
      inShift_ff  <= 32'h0000_0000;
    end else if (csRise) begin
      burstCnt_ff <= 6'h00;
      if (!burstOk) begin
        inCnt_ff <= 5'h00; // a torn burst also drops a pending half word
      end
    end else if (sclkFall && csLow) begin
      burstCnt_ff <= burstCnt_ff + 6'h01;
      inCnt_ff    <= inCnt_ff + 5'h01;
      inShift_ff  <= {inShift_ff[30:0], pinSync_ff[2]};
    end
  end

  // command decode once 32 bits sit in the shifter
  assign frameDone = csRise && burstOk && (inCnt_ff == 5'h00);
  assign isNull    = (inShift_ff == 32'h0000_0000);
  // RULE_06: register address field
  assign wrAddr    = inShift_ff[F_REG_HI:F_REG_LO];
  // RULE_07: write data field
  assign wrData    = inShift_ff[F_DATA_HI:F_DATA_LO];
  // RULE_12: same divider design for checking and answering
  bmc_crc12 u_inCrc (.data(inShift_ff[F_DEV_HI:F_DATA_LO]), .crc(inCrc));
  // RULE_11: mismatch blocks execution
  assign crcOk   = (inCrc == inShift_ff[F_CRC_HI:0]);
  // RULE_14: own address or broadcast
  assign addrHit = (inShift_ff[F_DEV_HI:F_DEV_LO] == devAddr_ff) ||
                   (inShift_ff[F_DEV_HI:F_DEV_LO] == DEV_BROADCAST);
  // null frames only clock out readback and never write
  assign exec    = frameDone && !isNull && crcOk && addrHit;

  // flag a corrupted command for the user side
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crcFault_ff <= 1'b0;
    end else begin
      crcFault_ff <= frameDone && !isNull && !crcOk;
    end
  end

  // register writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl1_ff   <= REG_RST;
      adcCtl_ff  <= REG_RST;
      pdtReg_ff  <= REG_RST;
      wdtReg_ff  <= WDT_RST;
      wdtKey_ff  <= REG_RST;
      rdSel_ff   <= REG_RST;
      devAddr_ff <= DEV_ADDR_RST;
      linkUni_ff <= 1'b0;
    end else if (exec) begin
      // RULE_08: bit 26 picks the next chain direction
      linkUni_ff <= inShift_ff[F_UNI];
      if (wrAddr == ADDR_CTRL1) begin
        ctrl1_ff <= wrData;
      end else if (wrAddr == ADDR_ADCCTL) begin
        adcCtl_ff <= wrData;
      end else if (wrAddr == ADDR_PDT) begin
        pdtReg_ff <= wrData;
      end else if (wrAddr == ADDR_WDT) begin
        wdtReg_ff <= wrData;
      end else if (wrAddr == ADDR_WKEY) begin
        wdtKey_ff <= wrData;
      end else if (wrAddr == ADDR_RDSEL) begin
        rdSel_ff <= wrData;
      end else if (wrAddr == ADDR_DEVADDR) begin
        devAddr_ff <= wrData[4:0];
      end
    end
  end

  // RULE_13: the selected register answers the next null frame
  always_comb begin
    if (rdSel_ff[5:0] == ADDR_CTRL1) begin
      rdVal = ctrl1_ff;
    end else if (rdSel_ff[5:0] == ADDR_ADCCTL) begin
      rdVal = adcCtl_ff;
    end else if (rdSel_ff[5:0] == ADDR_PDT) begin
      rdVal = pdtReg_ff;
    end else if (rdSel_ff[5:0] == ADDR_WDT) begin
      rdVal = wdtReg_ff;
    end else if (rdSel_ff[5:0] == ADDR_WKEY) begin
      rdVal = wdtKey_ff;
    end else if (rdSel_ff[5:0] == ADDR_DEVADDR) begin
      rdVal = {3'h0, devAddr_ff};
    end else if (rdSel_ff[5:0] == ADDR_RDSEL) begin
      rdVal = rdSel_ff;
    end else begin
      rdVal = REG_RST;
    end
  end
  assign rdHead = {devAddr_ff, 1'b0, rdSel_ff[5:0], rdVal};
  bmc_crc12 u_rdCrc (.data(rdHead), .crc(rdCrc));

  // RULE_05: a consumed result keeps only its life counter
  always_comb begin
    if (wide_ff) begin
      loadWord = convFresh_ff ? convBuf_ff : (convBuf_ff & LIFE_MASK);
    end else begin
      loadWord = {rdHead, rdCrc, 32'h0000_0000};
    end
  end

  // RULE_01: launch each outbound bit on the rising clock
  // RULE_03: word length follows the mode, 32 or 64
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outCnt_ff   <= 6'h00;
      outShift_ff <= 64'h0;
      miso_ff     <= 1'b0;
    end else if (csRise && !burstOk) begin
      outCnt_ff <= 6'h00;
    end else if (sclkRise && csLow) begin
      if (outCnt_ff == 6'h00) begin
        miso_ff     <= loadWord[63];
        outShift_ff <= {loadWord[62:0], 1'b0};
      end else begin
        miso_ff     <= outShift_ff[63];
        outShift_ff <= {outShift_ff[62:0], 1'b0};
      end
      if (outCnt_ff == 6'((wide_ff ? WORD_CONV : WORD_REG) - 7'h01)) begin
        outCnt_ff <= 6'h00;
      end else begin
        outCnt_ff <= outCnt_ff + 6'h01;
      end
    end
  end

  // conversion buffer; a new result beats a same-cycle consume
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      convBuf_ff   <= 64'h0;
      convFresh_ff <= 1'b0;
    end else if (convValid) begin
      convBuf_ff   <= convWord;
      convFresh_ff <= 1'b1;
    end else if (sclkRise && csLow && outCnt_ff == 6'h00 && wide_ff) begin
      convFresh_ff <= 1'b0;
    end
  end

  // RULE_04: conversions widen the word, code 0x04 narrows it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wide_ff <= 1'b0;
    end else if (convValid) begin
      wide_ff <= 1'b1;
    end else if (exec && wrAddr == ADDR_ADCCTL && wrData == ADC_NARROW_CODE) begin
      wide_ff <= 1'b0;
    end
  end

  // RULE_17: three back to back writes unlock the disable
  // RULE_18: any other command in between starts over
  always_comb begin
    nxt_wdSeq = WS_IDLE;
    case (wdSeq_ff)
      WS_IDLE: begin
        if (exec && wrAddr == ADDR_WDT && wrData == 8'h00) begin
          nxt_wdSeq = WS_ZERO;
        end
      end
      WS_ZERO: begin
        if (exec && wrAddr == ADDR_WKEY && wrData == WDT_KEY) begin
          nxt_wdSeq = WS_KEYED;
        end
      end
      default: begin
        nxt_wdSeq = WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdSeq_ff <= WS_IDLE;
    end else if (frameDone && !isNull) begin
      wdSeq_ff <= nxt_wdSeq;
    end
  end

  // RULE_15: step counter restarts on every timeout write
  // RULE_16: enabled out of reset with the default code
  // RULE_19: keeps running in partial power-down
  assign wdExpire = wdEn_ff && (wdtReg_ff != 8'h00) && (wdNum_ff >= wdtReg_ff);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdStep_ff <= 32'h0;
      wdNum_ff  <= 8'h00;
      wdEn_ff   <= 1'b1;
    end else if (exec && wrAddr == ADDR_WDT) begin
      wdStep_ff <= 32'h0;
      wdNum_ff  <= 8'h00;
      if (wrData != 8'h00) begin
        wdEn_ff <= 1'b1;
      end else if (wdSeq_ff == WS_KEYED) begin
        wdEn_ff <= 1'b0;
      end
    end else if (fullPd_ff) begin
      wdStep_ff <= 32'h0; // restart cleanly after wake
      wdNum_ff  <= 8'h00;
    end else if (wdEn_ff && wdtReg_ff != 8'h00 && !wdExpire) begin
      if (wdStep_ff == WDOG_STEP_CYC - 32'h1) begin
        wdStep_ff <= 32'h0;
        wdNum_ff  <= wdNum_ff + 8'h01;
      end else begin
        wdStep_ff <= wdStep_ff + 32'h1;
      end
    end
  end

  // power-down timer, armed by the hardware power-down bit
  assign hw_powerdown_select   = ctrl1_ff[CTRL1_HW_POWERDOWN_SELECT];
  assign pdDone = (pdtReg_ff == 8'h00) || (pdNum_ff >= pdtReg_ff);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pdStep_ff <= 32'h0;
      pdNum_ff  <= 8'h00;
    end else if ((exec && wrAddr == ADDR_PDT) || !hw_powerdown_select) begin
      pdStep_ff <= 32'h0;
      pdNum_ff  <= 8'h00;
    end else if (!pdDone) begin
      if (pdStep_ff == PDT_STEP_CYC - 32'h1) begin
        pdStep_ff <= 32'h0;
        pdNum_ff  <= pdNum_ff + 8'h01;
      end else begin
        pdStep_ff <= pdStep_ff + 32'h1;
      end
    end
  end

  // RULE_20: expiry latches until the wake pin toggles
  // RULE_22: timer end with wake still high does nothing here
  // RULE_23: zero timer means pdDone at once on wake low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fullPd_ff <= 1'b0;
    end else if (wdExpire || (hw_powerdown_select && !pinSync_ff[3] && pdDone)) begin
      fullPd_ff <= 1'b1;
    end else if (wakeEdge) begin
      fullPd_ff <= 1'b0;
    end
  end

  assign spi.miso  = miso_ff;
  assign linkUnidir = linkUni_ff;
  assign wideMode   = wide_ff;
  assign partialPd  = ctrl1_ff[CTRL1_SOFTPD];
  assign fullPd     = fullPd_ff;
  assign crcFault   = crcFault_ff;
endmodule

// file: rtl/bmc_pkg.sv
// shared constants for the battery monitor serial command port
package bmc_pkg;
  // system clock
  localparam int CLK_NS = 40;
  // link clock ceilings per chain direction, in kHz
  localparam int SCLK_UNI_MAX_KHZ = 725;
  localparam int SCLK_BI_MAX_KHZ  = 500;
  localparam int HALF_UNI_CALC =
    (1000000 + 2 * SCLK_UNI_MAX_KHZ * CLK_NS - 1) / (2 * SCLK_UNI_MAX_KHZ * CLK_NS);
  localparam int HALF_BI_CALC =
    (1000000 + 2 * SCLK_BI_MAX_KHZ * CLK_NS - 1) / (2 * SCLK_BI_MAX_KHZ * CLK_NS);
  localparam logic [15:0] HALF_UNI_CYC = 16'(HALF_UNI_CALC);
  localparam logic [15:0] HALF_BI_CYC  = 16'(HALF_BI_CALC);
  // bidirectional to unidirectional guard, 50 us
  localparam int GUARD_NS = 50000;
  localparam logic [15:0] GUARD_CYC = 16'((GUARD_NS + CLK_NS - 1) / CLK_NS);
  // watchdog step 8.192 ms, power-down timer step 2 minutes
  localparam int WDOG_STEP_NS = 8192000;
  localparam logic [31:0] WDOG_STEP_CYC_DEF = 32'(WDOG_STEP_NS / CLK_NS);
  localparam longint PDT_STEP_MS = 120000;
  localparam logic [31:0] PDT_STEP_CYC_DEF = 32'(PDT_STEP_MS * (1000000 / CLK_NS));
  // frame geometry
  localparam logic [5:0] BURST_SHORT = 6'h10;
  localparam logic [5:0] BURST_LONG  = 6'h20;
  localparam logic [6:0] WORD_REG    = 7'h20;
  localparam logic [6:0] WORD_CONV   = 7'h40;
  // command word fields
  localparam int F_DEV_HI  = 31;
  localparam int F_DEV_LO  = 27;
  localparam int F_UNI     = 26;
  localparam int F_REG_HI  = 25;
  localparam int F_REG_LO  = 20;
  localparam int F_DATA_HI = 19;
  localparam int F_DATA_LO = 12;
  localparam int F_CRC_HI  = 11;
  localparam logic [11:0] CRC_POLY = 12'h683;
  localparam logic [4:0]  DEV_BROADCAST = 5'h1f;
  localparam logic [4:0]  DEV_ADDR_RST  = 5'h00;
  // conversion packet life counter field
  localparam logic [63:0] LIFE_MASK = 64'h0380_0000_0000_0000;
  // register offsets
  localparam logic [5:0] ADDR_CTRL1   = 6'h01;
  localparam logic [5:0] ADDR_ADCCTL  = 6'h02;
  localparam logic [5:0] ADDR_PDT     = 6'h03;
  localparam logic [5:0] ADDR_WDT     = 6'h04;
  localparam logic [5:0] ADDR_WKEY    = 6'h05;
  localparam logic [5:0] ADDR_DEVADDR = 6'h06;
  localparam logic [5:0] ADDR_RDSEL   = 6'h3f;
  // control field positions and special values
  localparam int CTRL1_SOFTPD = 0;
  localparam int CTRL1_HW_POWERDOWN_SELECT   = 2;
  localparam logic [7:0] ADC_NARROW_CODE = 8'h04;
  localparam logic [7:0] WDT_RST         = 8'h0c;
  localparam logic [7:0] WDT_KEY         = 8'h5a;
  localparam logic [7:0] REG_RST         = 8'h00;
  localparam logic [3:0] PIN_IDLE        = 4'h2;
endpackage

// file: rtl/bmc_spi_if.sv
// serial link between host controller and monitor device
`timescale 1ns/1ns
interface bmc_spi_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic ioSupplyWake;
  modport host (output sclk, output csN, output mosi, output ioSupplyWake, input miso);
  modport dev  (input sclk, input csN, input mosi, input ioSupplyWake, output miso);
endinterface

// file: rtl/bmc_crc12.sv
// 12-bit command check code over the 20 header bits
`timescale 1ns/1ns
module bmc_crc12 import bmc_pkg::*; (
  input  wire logic [19:0] data,
  output logic      [11:0] crc
);
  logic [11:0] acc;
  logic        fb;

  // serial divider unrolled, msb first, seed zero
  always_comb begin
    acc = 12'h000;
    fb  = 1'b0;
    for (int i = 19; i >= 0; i--) begin
      fb  = data[i] ^ acc[11];
      acc = {acc[10:0], 1'b0} ^ ({12{fb}} & CRC_POLY);
    end
    crc = acc;
  end
endmodule

// file: rtl/bmc_host.sv
// host controller end: frames commands and null reads onto the link
`timescale 1ns/1ns
module bmc_host import bmc_pkg::*; (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  bmc_spi_if.host          spi,
  input  wire logic        cmdValid,
  input  wire logic [19:0] cmdHead,
  input  wire logic        cmdWide,
  input  wire logic        cmdSplit,
  output logic             cmdReady,
  input  wire logic        wakeReq,
  output logic             rspValid,
  output logic [63:0]      rspWord
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_HIGH = 3'b010,
    H_LOW  = 3'b011,
    H_GAP  = 3'b100
  } bmc_hstate_t;

  bmc_hstate_t state_ff;
  logic [15:0] tick_ff, guard_ff, halfCyc;
  logic [6:0]  bitCnt_ff, frameLen;
  logic [5:0]  burstCnt_ff, burstLen;
  logic [63:0] tx_ff, rx_ff, rspWord_ff;
  logic [11:0] cmdCrc;
  logic        wide_ff, split_ff, cmdUni_ff, nonNull_ff, linkUni_ff;
  logic        sclk_ff, csN_ff, mosi_ff, wake_ff, rspValid_ff;
  logic        misoMeta_ff, misoSync_ff, tickDone, guardOk;

  bmc_crc12 u_crc (.data(cmdHead), .crc(cmdCrc));

  // RULE_08: faster clock only while the chain is unidirectional
  // RULE_09: bidirectional frames use the slower clock
  assign halfCyc  = linkUni_ff ? HALF_UNI_CYC : HALF_BI_CYC;
  assign tickDone = (tick_ff == halfCyc - 16'h1);
  assign frameLen = wide_ff ? WORD_CONV : WORD_REG;
  assign burstLen = split_ff ? BURST_SHORT : BURST_LONG;

  // RULE_10: hold off a unidirectional command after bidirectional use
  assign guardOk  = linkUni_ff || (guard_ff >= GUARD_CYC);
  assign cmdReady = (state_ff == H_IDLE) && (!cmdHead[F_UNI - F_DATA_LO] || guardOk);

  // miso comes from the device domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      misoMeta_ff <= 1'b0;
      misoSync_ff <= 1'b0;
    end else begin
      misoMeta_ff <= spi.miso;
      misoSync_ff <= misoMeta_ff;
    end
  end

  // guard timer since the last frame run while the chain was bidirectional
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      guard_ff <= 16'h0;
    end else if (state_ff != H_IDLE && !linkUni_ff) begin
      guard_ff <= 16'h0;
    end else if (guard_ff != 16'hffff) begin
      guard_ff <= guard_ff + 16'h1;
    end
  end

  // frame sequencer
  // RULE_01: launch on rising, sample on falling, idle low
  // RULE_02: optional split into 16-bit bursts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff    <= H_IDLE;
      tick_ff     <= 16'h0;
      bitCnt_ff   <= 7'h00;
      burstCnt_ff <= 6'h00;
      tx_ff       <= 64'h0;
      rx_ff       <= 64'h0;
      wide_ff     <= 1'b0;
      split_ff    <= 1'b0;
      cmdUni_ff   <= 1'b0;
      nonNull_ff  <= 1'b0;
      linkUni_ff  <= 1'b0;
      sclk_ff     <= 1'b0;
      csN_ff      <= 1'b1;
      mosi_ff     <= 1'b0;
      rspValid_ff <= 1'b0;
      rspWord_ff  <= 64'h0;
    end else begin
      rspValid_ff <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          if (cmdValid && cmdReady) begin
            // RULE_11: every command carries its check code
            tx_ff       <= {cmdHead, cmdCrc, 32'h0000_0000};
            rx_ff       <= 64'h0;
            wide_ff     <= cmdWide;
            split_ff    <= cmdSplit;
            cmdUni_ff   <= cmdHead[F_UNI - F_DATA_LO];
            nonNull_ff  <= (cmdHead != 20'h0);
            bitCnt_ff   <= 7'h00;
            burstCnt_ff <= 6'h00;
            tick_ff     <= 16'h0;
            csN_ff      <= 1'b0;
            state_ff    <= H_LEAD;
          end
        end
        H_LEAD, H_LOW: begin
          if (!tickDone) begin
            tick_ff <= tick_ff + 16'h1;
          end else if (bitCnt_ff == frameLen || burstCnt_ff == burstLen) begin
            tick_ff  <= 16'h0;
            csN_ff   <= 1'b1;
            state_ff <= H_GAP;
          end else begin
            tick_ff  <= 16'h0;
            sclk_ff  <= 1'b1;
            mosi_ff  <= tx_ff[63];
            tx_ff    <= {tx_ff[62:0], 1'b0};
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (!tickDone) begin
            tick_ff <= tick_ff + 16'h1;
          end else begin
            tick_ff     <= 16'h0;
            sclk_ff     <= 1'b0;
            rx_ff       <= {rx_ff[62:0], misoSync_ff};
            bitCnt_ff   <= bitCnt_ff + 7'h01;
            burstCnt_ff <= burstCnt_ff + 6'h01;
            state_ff    <= H_LOW;
          end
        end
        H_GAP: begin
          if (!tickDone) begin
            tick_ff <= tick_ff + 16'h1;
          end else if (bitCnt_ff == frameLen) begin
            tick_ff     <= 16'h0;
            mosi_ff     <= 1'b0;
            rspValid_ff <= 1'b1;
            rspWord_ff  <= rx_ff;
            if (nonNull_ff) begin
              linkUni_ff <= cmdUni_ff; // direction holds for following null frames
            end
            state_ff <= H_IDLE;
          end else begin
            tick_ff     <= 16'h0;
            burstCnt_ff <= 6'h00;
            csN_ff      <= 1'b0;
            state_ff    <= H_LEAD;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // RULE_21: wake pin is driven as the user asks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= wakeReq;
    end
  end

  assign spi.sclk         = sclk_ff;
  assign spi.csN          = csN_ff;
  assign spi.mosi         = mosi_ff;
  assign spi.ioSupplyWake = wake_ff;
  assign rspValid         = rspValid_ff;
  assign rspWord          = rspWord_ff;
endmodule

// file: verif/bmc_chk.sv
// timing checks on the serial wires between host and device
`timescale 1ns/1ns
module bmc_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ioSupplyWake
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // clock rests low between frames
  idle_low_a: assert property (csN |-> !sclk)
    else $error("clock high outside a frame");
  // data steady at the capturing fall
  mosi_steady_a: assert property (!csN && $fell(sclk) |-> $stable(mosi))
    else $error("mosi moved at capture");
  miso_steady_a: assert property (!csN && $fell(sclk) |-> $stable(miso))
    else $error("miso moved at capture");
  // half period never shorter than the faster ceiling allows
  high_min_a: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*8] ##1 sclk[*2])
    else $error("clock high phase short");
  low_min_a: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 (!sclk)[*8] ##1 (!sclk)[*2])
    else $error("clock low phase short");
  // high half period bounded by the slower rate
  high_max_a: assert property ($rose(sclk) |-> ##[18:25] $fell(sclk))
    else $error("clock high phase long");
  // burst starts a half period after select falls; gaps last at least 9 cycles
  lead_a: assert property ($fell(csN) |-> ##[18:25] $rose(sclk))
    else $error("burst start late");
  gap_a: assert property ($rose(csN) |=> csN[*8])
    else $error("select gap short");
endmodule

// file: verif/battery_monitor_host_command_port_bench.sv
// bench: host and device ends face each other over the serial link
`timescale 1ns/1ns
module battery_monitor_host_command_port_bench;
  import bmc_pkg::*;
  logic        clock = 1'h0, sys_rst = 1'h1, cmdValid = 1'h0, cmdWide = 1'h0, cmdSplit = 1'h0;
  logic        wakeReq = 1'h0, convValid = 1'h0, cmdReady, rspValid, linkUnidir, wideMode;
  logic        partialPd, fullPd, crcFault;
  logic [19:0] cmdHead = 20'h00000, h, r;
  logic [63:0] convWord = 64'h8a5c_3e17_9b24_d6f1, rspWord;
  int          num_errors = 0, checks = 0, cyc = 0, waited = 0;
  bmc_spi_if   lnk();
  bmc_host i_bmc_host (.clock, .sys_rst, .spi(lnk), .cmdValid, .cmdHead, .cmdWide, .cmdSplit,
    .cmdReady, .wakeReq, .rspValid, .rspWord);
  // short watchdog and timer steps keep the run brief
  bmc_device #(.WDOG_STEP_CYC(32'h190), .PDT_STEP_CYC(32'h10)) i_bmc_device (.clock, .sys_rst,
    .spi(lnk), .convValid, .convWord, .linkUnidir, .wideMode, .partialPd, .fullPd, .crcFault);
  bmc_chk i_bmc_chk (.clock, .sys_rst, .sclk(lnk.sclk), .csN(lnk.csN), .mosi(lnk.mosi),
    .miso(lnk.miso), .ioSupplyWake(lnk.ioSupplyWake));
  initial begin
    forever #20 clock = ~clock;
  end
  // cycles since reset release
  always @(posedge clock) cyc <= sys_rst ? 0 : cyc + 1;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // bounded wait on {fullPd, rspValid, cmdReady}; a stuck flag ends the run
  task automatic await(input logic [2:0] m, input int lim);
    waited = 0;
    do begin
      @(negedge clock);
      waited++;
      if (waited > lim) begin
        num_errors++;
        finish_test();
      end
    end while (({fullPd, rspValid, cmdReady} & m) !== m);
  endtask
  // one frame through the host; answer lands in rspWord
  task automatic send(input logic [19:0] hd, input logic w, input logic s);
    @(posedge clock);
    cmdValid <= 1'h1;
    cmdHead <= hd;
    cmdWide <= w;
    cmdSplit <= s;
    await(3'h1, 4000);
    @(posedge clock);
    cmdValid <= 1'h0;
    await(3'h2, 9000);
  endtask
  // msb-first check code, cleared start
  function automatic logic [11:0] crc12(input logic [19:0] d);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 19; i >= 0; i--) c = {c[10:0], 1'h0} ^ ((c[11] ^ d[i]) ? CRC_POLY : 12'h000);
    return c;
  endfunction
  initial begin
    tick(6);
    sys_rst <= 1'h0;
    check(64'({linkUnidir, wideMode, partialPd, fullPd}), 64'h0);
    // read the watchdog code back through the select register
    send({5'h00, 1'h0, ADDR_RDSEL, 2'h0, ADDR_WDT}, 1'h0, 1'h0);
    send(20'h00000, 1'h0, 1'h0);
    r = {5'h00, 1'h0, ADDR_WDT, WDT_RST};
    check(64'(rspWord[31:0]), 64'({r, crc12(r)}));
    // untouched watchdog expires 12 steps of 400 clocks after reset
    await(3'h4, 2000);
    check(64'(cyc > 4790 && cyc < 4815), 64'h1);
    tick(40);
    check(64'(fullPd), 64'h1);
    wakeReq <= 1'h1;
    tick(8);
    check(64'(fullPd), 64'h0);
    // second timeout write restarts the count, else expiry comes early
    h = {5'h00, 1'h0, ADDR_WDT, 8'h05};
    send(h, 1'h0, 1'h0);
    send(h, 1'h0, 1'h0);
    r = 20'(cyc);
    await(3'h4, 2100);
    check(64'(cyc - int'(r) > 1950 && cyc - int'(r) < 2000), 64'h1);
    tick(1);
    wakeReq <= 1'h0;
    send({5'h00, 1'h0, ADDR_WDT, 8'h00}, 1'h0, 1'h0);
    // broadcast on a unidirectional frame must wait out the guard
    send({DEV_BROADCAST, 1'h1, ADDR_CTRL1, 8'h01}, 1'h0, 1'h0);
    check(64'({waited > 1200, linkUnidir, partialPd}), 64'h7);
    // other address ignored; own address in 16-bit bursts executes
    send({5'h03, 1'h1, ADDR_CTRL1, 8'h00}, 1'h0, 1'h1);
    check(64'(partialPd), 64'h1);
    send({5'h00, 1'h1, ADDR_CTRL1, 8'h00}, 1'h0, 1'h1);
    check(64'(partialPd), 64'h0);
    // conversion word: 64-bit mode, read once, reread keeps life count
    tick(1);
    convValid <= 1'h1;
    tick(1);
    convValid <= 1'h0;
    tick(2);
    check(64'(wideMode), 64'h1);
    send(20'h00000, 1'h1, 1'h0);
    check(rspWord, convWord);
    send(20'h00000, 1'h1, 1'h1);
    check(rspWord, convWord & LIFE_MASK);
    send({5'h00, 1'h1, ADDR_ADCCTL, ADC_NARROW_CODE}, 1'h1, 1'h0);
    check(64'(wideMode), 64'h0);
    // timer of 2 steps; power-down waits for the wake pin to fall
    tick(1);
    wakeReq <= 1'h1;
    send({5'h00, 1'h1, ADDR_PDT, 8'h02}, 1'h0, 1'h0);
    send({5'h00, 1'h1, ADDR_CTRL1, 8'h04}, 1'h0, 1'h0);
    tick(100);
    check(64'(fullPd), 64'h0);
    wakeReq <= 1'h0;
    tick(8);
    check(64'(fullPd), 64'h1);
    // zero timer with the hardware bit still set: wake low powers down at once
    wakeReq <= 1'h1;
    tick(8);
    send({5'h00, 1'h1, ADDR_PDT, 8'h00}, 1'h0, 1'h0);
    check(64'({fullPd, crcFault}), 64'h0);
    wakeReq <= 1'h0;
    tick(8);
    check(64'(fullPd), 64'h1);
    finish_test();
  end
endmodule
